// >>> piac_pkg.sv
// piac_pkg: constants, field layouts and types of the pi action and compare block
// assumes one clock domain and a plain register port with one-cycle read latency
package piac_pkg;
    // register byte offsets; command dword n sits at 4*n
    localparam logic [7:0] OFF_CTRL = 8'h40;
    localparam logic [7:0] OFF_NS_CFG = 8'h44;
    localparam logic [7:0] OFF_STATUS = 8'h48;
    localparam logic [7:0] OFF_PROGRESS = 8'h4c;
    // command dword indices
    localparam int DW_META_PTR_LO = 4;
    localparam int DW_DATA_PTR_LO = 6;
    localparam int DW_PI_CTRL = 12;
    localparam int DW_REF_TAG = 14;
    localparam int DW_APP_TAG = 15;
    // fields of dword 12 and of the pi field
    localparam int BLK_CNT_LSB = 0;
    localparam int PI_FIELD_LSB = 26;
    localparam int PI_ACT_BIT = 3;
    localparam int PI_CHK_GUARD = 2;
    localparam int PI_CHK_APP = 1;
    localparam int PI_CHK_REF = 0;
    // control, namespace config and status fields
    localparam int CTRL_START = 0;
    localparam int CTRL_OP_LSB = 1;
    localparam int CTRL_SGL = 3;
    localparam int CFG_PI_EN = 0;
    localparam int CFG_PI_LAST = 1;
    localparam int CFG_META_LSB = 4;
    localparam int STS_BUSY = 0;
    localparam int STS_CODE_LSB = 8;
    // protection tuple layout inside one 64-bit beat
    localparam int TUP_GUARD_LSB = 48;
    localparam int TUP_APP_LSB = 32;
    localparam int TUP_REF_LSB = 0;
    // reset values
    localparam logic [31:0] CMD_DW_RST = 32'h0000_0000;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [15:0] GUARD_SEED = 16'h0000;
    // completion status codes
    localparam logic [7:0] STS_SUCCESS = 8'h00;
    localparam logic [7:0] STS_INVALID_PI = 8'h81;
    localparam logic [7:0] STS_GUARD_ERR = 8'ha0;
    localparam logic [7:0] STS_APP_ERR = 8'ha1;
    localparam logic [7:0] STS_REF_ERR = 8'ha2;
    localparam logic [7:0] STS_CMP_FAIL = 8'ha3;

    typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE, OP_COMPARE} piac_op_type;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_INSERT, ST_DONE} piac_state_type;
endpackage : piac_pkg

// >>> piac_tuple_if.sv
// piac_tuple_if: one protection tuple with its expected fields and check results
// assumes the core drives the tuple side and the checker answers combinationally
`timescale 1ns/1ns
interface piac_tuple_if;
    logic [63:0] tuple;
    logic [15:0] guard_calc;
    logic [31:0] exp_ref;
    logic [15:0] exp_app;
    logic [15:0] app_mask;
    logic [2:0] check_sel;
    logic guard_err;
    logic app_err;
    logic ref_err;

    modport chk (
        input tuple, guard_calc, exp_ref, exp_app, app_mask, check_sel,
        output guard_err, app_err, ref_err
    );
    modport core (
        output tuple, guard_calc, exp_ref, exp_app, app_mask, check_sel,
        input guard_err, app_err, ref_err
    );
endinterface : piac_tuple_if

// >>> piac_tuple_chk.sv
// piac_tuple_chk: field-by-field check of one protection tuple
// assumes check_sel is already forced to zero when the namespace carries no pi
`timescale 1ns/1ns
module piac_tuple_chk (
    // tuple and expectations
    piac_tuple_if.chk pi
);
    // each field flags only while its select bit is set
    always_comb begin
        pi.guard_err = pi.check_sel[piac_pkg::PI_CHK_GUARD]
            && (pi.tuple[piac_pkg::TUP_GUARD_LSB +: 16] != pi.guard_calc);
        pi.app_err = pi.check_sel[piac_pkg::PI_CHK_APP]
            && (((pi.tuple[piac_pkg::TUP_APP_LSB +: 16] ^ pi.exp_app) & pi.app_mask)
            != 16'h0000);
        pi.ref_err = pi.check_sel[piac_pkg::PI_CHK_REF]
            && (pi.tuple[piac_pkg::TUP_REF_LSB +: 32] != pi.exp_ref);
    end
endmodule : piac_tuple_chk

// >>> piac_guard.sv
// piac_guard: one 64-bit step of the running guard crc, msb first
// assumes the caller holds the running value and reseeds it per block
`timescale 1ns/1ns
module piac_guard #(
    parameter logic [15:0] POLY = 16'h8bb7
) (
    // running value in and out
    input wire logic [15:0] crc_i,
    input wire logic [63:0] data_i,
    output logic [15:0] crc_o
);
    function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [63:0] data);
        logic [15:0] c;
        c = crc;
        for (int i = 63; i >= 0; i--) begin
            c = (c[15] ^ data[i]) ? ({c[14:0], 1'b0} ^ POLY) : {c[14:0], 1'b0};
        end
        return c;
    endfunction : crc_step

    // unrolled by synthesis; one beat per clock keeps the stream at full rate
    always_comb begin
        crc_o = crc_step(crc_i, data_i);
    end
endmodule : piac_guard

// >>> piac_core.sv
// piac_core: pi action and check handling plus the compare command engine
// assumes synchronous inputs on ref_clk_i, a beat sink that never stalls, and
// a source that presents medium and host beats of a compare side by side
`timescale 1ns/1ns
module piac_core #(
    parameter int DATA_BEATS = 64
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic reset_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // beat stream in
    input wire logic beat_valid_i,
    input wire logic [63:0] medium_data_i,
    input wire logic [63:0] host_data_i,
    output logic beat_ready_o,
    // beat stream out
    output logic out_valid_o,
    output logic [63:0] out_data_o,
    // completion
    output logic cpl_valid_o,
    output logic [7:0] cpl_status_o,
    // transfer description
    output logic [127:0] data_buffer_pointer_o,
    output logic [63:0] metadata_buffer_pointer_o,
    output logic xfer_sgl_o,
    output logic busy_o
);
    localparam int BCW = $clog2(DATA_BEATS + 16);
    localparam logic [BCW-1:0] DATA_BEATS_W = BCW'(DATA_BEATS);

    // refuse block sizes the beat counter cannot hold
    if (DATA_BEATS < 1 || DATA_BEATS > 4096) begin : g_bad_size
        $error("piac_core: DATA_BEATS must be 1 to 4096");
    end

    // register file state
    logic [31:0] cmd_dw_reg [16];
    logic [31:0] cmd_dw_next [16];
    piac_pkg::piac_op_type op_reg, op_next;
    logic sgl_reg, sgl_next;
    logic [7:0] cfg_reg, cfg_next;
    logic [31:0] rdata_reg, rdata_next;
    logic start;
    piac_pkg::piac_op_type op_start;

    // engine state
    piac_pkg::piac_state_type state_reg, state_next;
    logic [BCW-1:0] beat_cnt_reg, beat_cnt_next;
    logic [15:0] blk_idx_reg, blk_idx_next;
    logic [15:0] crc_reg, crc_next;
    logic [7:0] err_reg, err_next;
    logic ready_reg, ready_next;
    logic out_valid_reg, out_valid_next;
    logic [63:0] out_data_reg, out_data_next;
    logic cpl_valid_reg, cpl_valid_next;
    logic [7:0] cpl_status_reg, cpl_status_next;
    logic [127:0] data_ptr_reg, data_ptr_next;
    logic [63:0] meta_ptr_reg, meta_ptr_next;
    logic xsgl_reg, xsgl_next;
    logic busy_reg, busy_next;

    // decoded command and namespace settings
    logic [3:0] pi_control_field;
    logic [3:0] meta_beats;
    logic pi_present, pi_action_bit, ins_mode, taken, is_data, is_pi, last_beat;
    logic [2:0] pi_check_select;
    logic [BCW-1:0] meta_idx, src_beats;
    logic [15:0] block_count_minus_one;
    logic [63:0] src_data, gen_tuple;
    logic [15:0] guard_out;
    logic [31:0] exp_ref;

    piac_tuple_if pi_if ();

    piac_tuple_chk u_chk (
        .pi(pi_if.chk)
    );

    piac_guard u_guard (
        .crc_i(crc_reg),
        .data_i(src_data),
        .crc_o(guard_out)
    );

    // settings are live from the command dwords; writes are refused while busy
    always_comb begin
        pi_control_field = cmd_dw_reg[piac_pkg::DW_PI_CTRL][piac_pkg::PI_FIELD_LSB +: 4];
        block_count_minus_one = cmd_dw_reg[piac_pkg::DW_PI_CTRL][piac_pkg::BLK_CNT_LSB +: 16];
        meta_beats = cfg_reg[piac_pkg::CFG_META_LSB +: 4];
        pi_present = cfg_reg[piac_pkg::CFG_PI_EN] && (meta_beats != 4'h0);
        pi_action_bit = pi_present && pi_control_field[piac_pkg::PI_ACT_BIT];
        pi_check_select = pi_present ? pi_control_field[2:0] : 3'b000;
        ins_mode = pi_action_bit && (meta_beats == 4'h1);
        src_beats = (op_reg == piac_pkg::OP_WRITE && ins_mode) ? DATA_BEATS_W
            : DATA_BEATS_W + BCW'(meta_beats);
        is_data = beat_cnt_reg < DATA_BEATS_W;
        meta_idx = beat_cnt_reg - DATA_BEATS_W;
        is_pi = pi_present && !is_data && (cfg_reg[piac_pkg::CFG_PI_LAST]
            ? (meta_idx == BCW'(meta_beats) - BCW'(1)) : (meta_idx == '0));
        last_beat = beat_cnt_reg == src_beats - BCW'(1);
        taken = beat_valid_i && ready_reg;
        src_data = (op_reg == piac_pkg::OP_WRITE) ? host_data_i : medium_data_i;
        exp_ref = cmd_dw_reg[piac_pkg::DW_REF_TAG] + {16'h0000, blk_idx_reg};
        gen_tuple = {crc_reg, cmd_dw_reg[piac_pkg::DW_APP_TAG][15:0], exp_ref};
    end

    // tuple under check is always the source beat
    assign pi_if.tuple = src_data;
    assign pi_if.guard_calc = crc_reg;
    assign pi_if.exp_ref = exp_ref;
    assign pi_if.exp_app = cmd_dw_reg[piac_pkg::DW_APP_TAG][15:0];
    assign pi_if.app_mask = cmd_dw_reg[piac_pkg::DW_APP_TAG][31:16];
    assign pi_if.check_sel = pi_check_select;

    // register writes, start strobe and read mux
    always_comb begin
        cmd_dw_next = cmd_dw_reg;
        op_next = op_reg;
        sgl_next = sgl_reg;
        cfg_next = cfg_reg;
        rdata_next = 32'h0000_0000;
        start = 1'b0;
        op_start = piac_pkg::piac_op_type'(reg_wdata_i[piac_pkg::CTRL_OP_LSB +: 2]);
        if (reg_wr_i && state_reg == piac_pkg::ST_IDLE) begin
            if (reg_addr_i < piac_pkg::OFF_CTRL && reg_addr_i[1:0] == 2'b00) begin
                cmd_dw_next[reg_addr_i[5:2]] = reg_wdata_i;
            end else if (reg_addr_i == piac_pkg::OFF_CTRL) begin
                op_next = op_start;
                sgl_next = reg_wdata_i[piac_pkg::CTRL_SGL];
                start = reg_wdata_i[piac_pkg::CTRL_START] && op_start != piac_pkg::OP_NONE;
            end else if (reg_addr_i == piac_pkg::OFF_NS_CFG) begin
                cfg_next = reg_wdata_i[7:0];
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i < piac_pkg::OFF_CTRL && reg_addr_i[1:0] == 2'b00) begin
                rdata_next = cmd_dw_reg[reg_addr_i[5:2]];
            end else begin
                case (reg_addr_i)
                    piac_pkg::OFF_CTRL: rdata_next = {28'h000_0000, sgl_reg, op_reg, 1'b0};
                    piac_pkg::OFF_NS_CFG: rdata_next = {24'h00_0000, cfg_reg};
                    piac_pkg::OFF_STATUS: rdata_next = {16'h0000, cpl_status_reg, 7'h00, busy_reg};
                    piac_pkg::OFF_PROGRESS: rdata_next = {blk_idx_reg, 8'h00, err_reg};
                    default: rdata_next = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            for (int i = 0; i < 16; i++) begin
                cmd_dw_reg[i] <= piac_pkg::CMD_DW_RST;
            end
            op_reg <= piac_pkg::OP_NONE;
            sgl_reg <= 1'b0;
            cfg_reg <= piac_pkg::CFG_RST;
            rdata_reg <= 32'h0000_0000;
        end else begin
            cmd_dw_reg <= cmd_dw_next;
            op_reg <= op_next;
            sgl_reg <= sgl_next;
            cfg_reg <= cfg_next;
            rdata_reg <= rdata_next;
        end
    end

    // command engine: whole range runs even after a check or compare error so the stream stays aligned
    always_comb begin
        state_next = state_reg;
        beat_cnt_next = beat_cnt_reg;
        blk_idx_next = blk_idx_reg;
        crc_next = crc_reg;
        err_next = err_reg;
        out_valid_next = 1'b0;
        out_data_next = out_data_reg;
        cpl_valid_next = 1'b0;
        cpl_status_next = cpl_status_reg;
        data_ptr_next = data_ptr_reg;
        meta_ptr_next = meta_ptr_reg;
        xsgl_next = xsgl_reg;
        case (state_reg)
            piac_pkg::ST_IDLE: begin
                if (start) begin
                    // same fields serve prp and sgl; the flag says which
                    data_ptr_next = {cmd_dw_reg[piac_pkg::DW_DATA_PTR_LO + 3],
                        cmd_dw_reg[piac_pkg::DW_DATA_PTR_LO + 2],
                        cmd_dw_reg[piac_pkg::DW_DATA_PTR_LO + 1],
                        cmd_dw_reg[piac_pkg::DW_DATA_PTR_LO]};
                    meta_ptr_next = {cmd_dw_reg[piac_pkg::DW_META_PTR_LO + 1],
                        cmd_dw_reg[piac_pkg::DW_META_PTR_LO]};
                    xsgl_next = reg_wdata_i[piac_pkg::CTRL_SGL];
                    beat_cnt_next = '0;
                    blk_idx_next = 16'h0000;
                    crc_next = piac_pkg::GUARD_SEED;
                    err_next = piac_pkg::STS_SUCCESS;
                    if (op_start == piac_pkg::OP_COMPARE && pi_action_bit) begin
                        err_next = piac_pkg::STS_INVALID_PI;
                        state_next = piac_pkg::ST_DONE;
                    end else begin
                        state_next = piac_pkg::ST_RUN;
                    end
                end
            end
            piac_pkg::ST_RUN: begin
                if (taken) begin
                    if (is_data) begin
                        crc_next = guard_out;
                    end
                    // first error found keeps its status to the end
                    if (err_reg == piac_pkg::STS_SUCCESS) begin
                        if (is_pi && !(op_reg == piac_pkg::OP_WRITE && pi_action_bit)) begin
                            if (pi_if.guard_err) begin
                                err_next = piac_pkg::STS_GUARD_ERR;
                            end else if (pi_if.app_err) begin
                                err_next = piac_pkg::STS_APP_ERR;
                            end else if (pi_if.ref_err) begin
                                err_next = piac_pkg::STS_REF_ERR;
                            end
                        end else if (op_reg == piac_pkg::OP_COMPARE
                            && medium_data_i != host_data_i) begin
                            err_next = piac_pkg::STS_CMP_FAIL;
                        end
                    end
                    if (op_reg == piac_pkg::OP_READ) begin
                        out_valid_next = !(is_pi && ins_mode);
                        out_data_next = medium_data_i;
                    end else if (op_reg == piac_pkg::OP_WRITE) begin
                        out_valid_next = 1'b1;
                        out_data_next = (is_pi && pi_action_bit) ? gen_tuple : host_data_i;
                    end
                    if (!last_beat) begin
                        beat_cnt_next = beat_cnt_reg + BCW'(1);
                    end else begin
                        beat_cnt_next = '0;
                        if (op_reg == piac_pkg::OP_WRITE && ins_mode) begin
                            state_next = piac_pkg::ST_INSERT;
                        end else begin
                            crc_next = piac_pkg::GUARD_SEED;
                            blk_idx_next = blk_idx_reg + 16'h0001;
                            if (blk_idx_reg == block_count_minus_one) begin
                                state_next = piac_pkg::ST_DONE;
                            end
                        end
                    end
                end
            end
            piac_pkg::ST_INSERT: begin
                out_valid_next = 1'b1;
                out_data_next = gen_tuple;
                crc_next = piac_pkg::GUARD_SEED;
                blk_idx_next = blk_idx_reg + 16'h0001;
                state_next = (blk_idx_reg == block_count_minus_one) ? piac_pkg::ST_DONE
                    : piac_pkg::ST_RUN;
            end
            piac_pkg::ST_DONE: begin
                cpl_valid_next = 1'b1;
                cpl_status_next = err_reg;
                state_next = piac_pkg::ST_IDLE;
            end
            default: state_next = piac_pkg::ST_IDLE;
        endcase
        ready_next = state_next == piac_pkg::ST_RUN;
        busy_next = state_next != piac_pkg::ST_IDLE;
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg <= piac_pkg::ST_IDLE;
            beat_cnt_reg <= '0;
            blk_idx_reg <= 16'h0000;
            crc_reg <= piac_pkg::GUARD_SEED;
            err_reg <= piac_pkg::STS_SUCCESS;
            ready_reg <= 1'b0;
            out_valid_reg <= 1'b0;
            out_data_reg <= 64'h0000_0000_0000_0000;
            cpl_valid_reg <= 1'b0;
            cpl_status_reg <= piac_pkg::STS_SUCCESS;
            data_ptr_reg <= '0;
            meta_ptr_reg <= 64'h0000_0000_0000_0000;
            xsgl_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            beat_cnt_reg <= beat_cnt_next;
            blk_idx_reg <= blk_idx_next;
            crc_reg <= crc_next;
            err_reg <= err_next;
            ready_reg <= ready_next;
            out_valid_reg <= out_valid_next;
            out_data_reg <= out_data_next;
            cpl_valid_reg <= cpl_valid_next;
            cpl_status_reg <= cpl_status_next;
            data_ptr_reg <= data_ptr_next;
            meta_ptr_reg <= meta_ptr_next;
            xsgl_reg <= xsgl_next;
            busy_reg <= busy_next;
        end
    end

    // outputs straight from flops
    assign reg_rdata_o = rdata_reg;
    assign beat_ready_o = ready_reg;
    assign out_valid_o = out_valid_reg;
    assign out_data_o = out_data_reg;
    assign cpl_valid_o = cpl_valid_reg;
    assign cpl_status_o = cpl_status_reg;
    assign data_buffer_pointer_o = data_ptr_reg;
    assign metadata_buffer_pointer_o = meta_ptr_reg;
    assign xfer_sgl_o = xsgl_reg;
    assign busy_o = busy_reg;

    // checks on the engine
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);

    sequence s_done;
        state_reg == piac_pkg::ST_DONE;
    endsequence
    sequence s_cpl_pulse;
        cpl_valid_o ##1 !cpl_valid_o;
    endsequence

    AST_NO_PI_NO_TUPLE: assert property (
        !cfg_reg[piac_pkg::CFG_PI_EN] |-> !is_pi && !pi_if.guard_err && !pi_if.ref_err)
        else $error("pi handling active without pi namespace");
    AST_STRIP_ON_READ: assert property (
        taken && op_reg == piac_pkg::OP_READ && is_pi && ins_mode |=> !out_valid_o)
        else $error("tuple not stripped on read");
    AST_INSERT_ON_WRITE: assert property (
        state_reg == piac_pkg::ST_INSERT |=> out_valid_o && out_data_o == $past(gen_tuple))
        else $error("generated tuple not inserted");
    AST_PASS_ON_READ: assert property (
        taken && op_reg == piac_pkg::OP_READ && !pi_action_bit
        |=> out_valid_o && out_data_o == $past(medium_data_i))
        else $error("read beat not passed");
    AST_GUARD_STATUS: assert property (
        taken && is_pi && op_reg == piac_pkg::OP_READ && pi_if.guard_err
        && err_reg == piac_pkg::STS_SUCCESS |=> err_reg == piac_pkg::STS_GUARD_ERR)
        else $error("guard error not recorded");
    AST_PI_NOT_COMPARED: assert property (
        taken && op_reg == piac_pkg::OP_COMPARE && is_pi && err_reg == piac_pkg::STS_SUCCESS
        && !pi_if.guard_err && !pi_if.app_err && !pi_if.ref_err
        |=> err_reg == piac_pkg::STS_SUCCESS)
        else $error("tuple bytes took part in compare");
    AST_MISCOMPARE: assert property (
        taken && op_reg == piac_pkg::OP_COMPARE && !is_pi && medium_data_i != host_data_i
        && err_reg == piac_pkg::STS_SUCCESS |=> err_reg == piac_pkg::STS_CMP_FAIL)
        else $error("miscompare not recorded");
    AST_INVALID_PI: assert property (
        start && op_start == piac_pkg::OP_COMPARE && pi_action_bit
        |-> ##2 cpl_valid_o && cpl_status_o == piac_pkg::STS_INVALID_PI)
        else $error("invalid pi compare not failed with 81h");
    AST_COMPLETION: assert property (
        s_done |=> s_cpl_pulse and cpl_status_o == $past(err_reg))
        else $error("completion not posted with status");
    AST_BLOCK_COUNT: assert property (
        taken && last_beat && !ins_mode && blk_idx_reg != block_count_minus_one
        |=> state_reg == piac_pkg::ST_RUN)
        else $error("command ended before block count");
endmodule : piac_core

// >>> piac_host_model.sv
// piac_host_model: host and medium beat source facing the compare engine
// assumes beats are taken on any edge with valid and ready both high
`timescale 1ns/1ns
module piac_host_model (
    // clock, reset and mode
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic slow_i,
    input wire logic beat_ready_i,
    input wire logic [63:0] med_val_i,
    input wire logic [63:0] host_val_i,
    // beats to the engine
    output logic beat_valid_o,
    output logic [63:0] medium_data_o,
    output logic [63:0] host_data_o
);
    // slow mode idles one cycle after a taken beat, else valid holds until taken
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            beat_valid_o <= 1'b0;
        end else begin
            beat_valid_o <= !(slow_i && beat_valid_o && beat_ready_i);
        end
    end
    // idle lines show inverted data so stale values never pass
    assign medium_data_o = beat_valid_o ? med_val_i : ~med_val_i;
    assign host_data_o = beat_valid_o ? host_val_i : ~host_val_i;
endmodule : piac_host_model

// >>> pi_action_and_compare_test.sv
// pi_action_and_compare_test: row-driven bench of the pi action and compare engine
// assumes one data beat per block and a beat sink that never stalls
`timescale 1ns/1ns
module pi_action_and_compare_test;
    typedef struct packed {
        logic [1:0] op; logic [7:0] cfg; logic [3:0] pi; logic [31:0] d14;
        logic [31:0] d15; logic [63:0] med; logic [63:0] host; logic [7:0] sts; logic [2:0] outs;
    } piac_row_type;
    // op, ns cfg, pi field, dw14, dw15, medium, host, status, output beats
    piac_row_type rows [13] = '{
        '{3, 8'h00, 0, 0, 0, 5, 5, 8'h00, 0}, '{3, 8'h00, 0, 0, 0, 5, 6, 8'ha3, 0},
        '{3, 8'h11, 8, 0, 0, 5, 5, 8'h81, 0}, '{3, 8'h10, 15, 0, 0, 5, 5, 8'h00, 0},
        '{3, 8'h11, 4, 0, 0, 1, 1, 8'ha0, 0}, '{3, 8'h11, 1, 2, 0, 0, 0, 8'ha2, 0},
        '{3, 8'h11, 2, 0, 32'hffff_0003, 0, 0, 8'ha1, 0},
        '{3, 8'h11, 0, 2, 32'hffff_0003, 1, 1, 8'h00, 0}, '{1, 8'h11, 8, 0, 0, 5, 5, 8'h00, 1},
        '{1, 8'h11, 4, 0, 0, 5, 5, 8'ha0, 2}, '{2, 8'h11, 8, 0, 0, 5, 5, 8'h00, 2},
        '{2, 8'h21, 8, 0, 0, 5, 5, 8'h00, 3}, '{1, 8'h21, 8, 0, 0, 5, 5, 8'h00, 3}};
    logic ref_clk_i = 0, reset_i = 1, reg_wr_i = 0, reg_rd_i = 0, slow = 0;
    logic [7:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o, v;
    logic [63:0] med = 0, host = 0, medium_data_i, host_data_i, out_data_o, mp;
    logic beat_valid_i, beat_ready_o, out_valid_o, cpl_valid_o, xfer_sgl_o, busy_o;
    logic [7:0] cpl_status_o;
    logic [127:0] dp;
    int mismatches = 0, comparisons = 0, outs = 0, n;
    piac_row_type r;
    piac_core #(.DATA_BEATS(1)) piac_core_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .beat_valid_i(beat_valid_i),
        .medium_data_i(medium_data_i), .host_data_i(host_data_i), .beat_ready_o(beat_ready_o),
        .out_valid_o(out_valid_o), .out_data_o(out_data_o), .cpl_valid_o(cpl_valid_o),
        .cpl_status_o(cpl_status_o), .data_buffer_pointer_o(dp),
        .metadata_buffer_pointer_o(mp), .xfer_sgl_o(xfer_sgl_o), .busy_o(busy_o));
    piac_host_model piac_host_model_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .slow_i(slow), .beat_ready_i(beat_ready_o), .med_val_i(med), .host_val_i(host),
        .beat_valid_o(beat_valid_i), .medium_data_o(medium_data_i), .host_data_o(host_data_i));
    // 25 MHz clock and output beat counter
    initial forever #20 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) if (out_valid_o === 1'b1) outs++;
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge ref_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge ref_clk_i);
        reg_rd_i <= 1'b0;
        #1 v = reg_rdata_o;
    endtask : rd
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    // watchdog far beyond the few hundred cycles the rows need
    initial begin
        #200000;
        mismatches++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        chk({busy_o, cpl_status_o}, 0);
        // pointer dwords 4..9 written once; dwords 12, 14 and 15 set per row, the rest left zero
        for (int k = 4; k < 10; k++) wr(8'(4 * k), 32'h1000_0000 + k);
        foreach (rows[i]) begin
            r = rows[i];
            slow <= i[1];
            med <= r.med;
            host <= r.host;
            wr(8'h30, {2'b00, r.pi, 26'h000_0000});
            wr(8'h38, r.d14);
            wr(8'h3c, r.d15);
            wr(8'h44, {24'h00_0000, r.cfg});
            outs = 0;
            wr(8'h40, {28'h000_0000, i[0], r.op, 1'b1});
            for (n = 0; n < 60 && cpl_valid_o !== 1'b1; n++) @(posedge ref_clk_i) #1;
            chk(cpl_valid_o, 1'b1);
            chk(cpl_status_o, r.sts);
            chk(outs, r.outs);
            // crc of data beat 5 with zero app and ref tags
            if (i == 10) chk(out_data_o, 64'h39b2_0000_0000_0000);
            chk(xfer_sgl_o, i[0]);
            rd(8'h48);
            chk(v, {16'h0000, r.sts, 8'h00});
        end
        chk(dp, {32'h1000_0009, 32'h1000_0008, 32'h1000_0007, 32'h1000_0006});
        chk(mp, {32'h1000_0005, 32'h1000_0004});
        rd(8'h80);
        chk(v, 0);
        // two blocks, no action: every beat passes and the block index ends at two
        wr(8'h30, 32'h0000_0001);
        outs = 0;
        wr(8'h40, 32'h0000_0003);
        for (n = 0; n < 60 && cpl_valid_o !== 1'b1; n++) @(posedge ref_clk_i) #1;
        chk({cpl_valid_o, cpl_status_o}, 9'h100);
        chk(outs, 6);
        chk(out_data_o, 5);
        rd(8'h4c);
        chk(v, 32'h0002_0000);
        // reset in mid-command must drop the engine and clear the command words
        wr(8'h40, 32'h0000_0003);
        #1 chk(busy_o, 1);
        @(posedge ref_clk_i);
        reset_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        @(posedge ref_clk_i) #1;
        chk({busy_o, beat_ready_o, cpl_valid_o, out_valid_o, cpl_status_o, out_data_o}, 0);
        rd(8'h30);
        chk(v, 0);
        stop_test();
    end
endmodule : pi_action_and_compare_test
